// ==== src/scos_top.sv ====
// Behaviour
// - Auto-calibrate loops after reset once crystal present.
// - Mute selected outputs until source loop ready.
// - Rising loop enable recalibrates that loop only.
// - Divided resonator clock skips one output bank.
// - Second synth post-divider ranges 2 to 13.
// - First synth post-dividers 2 to 7 each.
// - Each reference has 16-bit divider.
// - Comparator emits phase-error correction word.
// - Loop filter drives synth fractional numerator.
// - Feedback prescaler 33 bits, nonzero.
// - Feedback divider: 33-bit int, 40-bit fraction.
// - Sync request aligns enabled output channels.
// - Outputs 0, 4, 10 offer zero-delay align.
// - Outputs 0, 1 select among six sources.
// - Outputs 2, 3 select among three sources.
// - Output pairs 4-13 share two-way selector.
// - Reference source needs route bit, one-hot field.
// - Digital-loop synth uses fixed 24-bit denominator.
`timescale 1ns/1ps
`default_nettype none

module scos_top
  import scos_pkg::*;
#(
  parameter int DL_SYNTH = LOOP_RES,
  parameter int LF_SHIFT = LF_SHIFT_DEF
)
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic soft_rst,
  input wire logic xo_present,
  input wire logic [NUM_LOOPS-1:0] loop_lock,
  input wire logic [NUM_REFS-1:0] ref_in,
  input wire logic fb_in,
  input wire logic [NUM_LOOPS-1:0] synth_loop_enable,
  input wire logic [NUM_LOOPS-1:0] dl_mode,
  input wire scos_pdiv_t pdiv_cfg,
  input wire scos_fb_t fb_cfg,
  input wire logic [NUM_LOOPS-1:0][DEN24_W-1:0] den24_cfg,
  input wire logic [NUM_REFS-1:0][REF_DIV_W-1:0] ref_div_cfg,
  input wire logic [$clog2(NUM_REFS)-1:0] ref_sel,
  input wire scos_src_t [NUM_OUTS-1:0] src_cfg,
  input wire logic ref_route_en,
  input wire logic [4:0] ref_route_sel,
  input wire logic [NUM_OUTS-1:0] mute_sel,
  input wire logic sync_req,
  input wire logic [NUM_OUTS-1:0] sync_en,
  input wire logic [2:0] zda_en,
  input wire logic [ZDA_OFS_W-1:0] zda_offset_cfg,
  output logic [NUM_LOOPS-1:0] cal_run,
  output logic [NUM_LOOPS-1:0] loop_ready,
  output scos_pdiv_t pdiv,
  output scos_fb_t fb,
  output logic fb_reject,
  output logic [NUM_LOOPS-1:0] den_fixed,
  output logic [NUM_LOOPS-1:0][DEN24_W-1:0] den24,
  output logic [FRAC_W-1:0] dl_num,
  output logic signed [PH_W:0] corr_word,
  output logic corr_valid,
  output scos_src_t [NUM_OUTS-1:0] out_src,
  output logic [NUM_OUTS-1:0] src_live,
  output logic [4:0] ref_route,
  output logic [NUM_OUTS-1:0] out_mute,
  output logic [NUM_OUTS-1:0] out_sync,
  output logic [2:0] zda_active,
  output logic [ZDA_OFS_W-1:0] zda_offset
);

  if (DL_SYNTH < 0 || DL_SYNTH >= NUM_LOOPS || LF_SHIFT < 0 || LF_SHIFT > 22)
  begin : g_bad_param
    $error("Loop selection or filter shift out of range.");
  end

  // ********************
  // Pin synchronisers
  // ********************
  logic [SYNC_W-1:0] s1_r, s2_r, s3_r;
  logic xo_ok, fb_edge;
  logic [NUM_LOOPS-1:0] lock_s;
  logic [NUM_REFS-1:0] ref_edge;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end
    else if (ce)
    begin
      s1_r <= {fb_in, ref_in, loop_lock, xo_present};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign xo_ok = s2_r[0];
  assign lock_s = s2_r[3:1];
  assign ref_edge = s2_r[7:4] & ~s3_r[7:4];
  assign fb_edge = s2_r[8] & ~s3_r[8];

  // ********************
  // Configuration
  // ********************
  logic [NUM_LOOPS-1:0] en_q_r, en_rise;
  scos_pdiv_t pdiv_r, pdiv_nxt;
  scos_fb_t fb_r, fb_nxt;
  logic fb_rej_r, fb_rej_nxt;
  scos_src_t [NUM_OUTS-1:0] out_src_r, out_src_nxt;
  logic [4:0] ref_route_r, ref_route_nxt;
  logic [NUM_LOOPS-1:0] den_fixed_r, den_fixed_nxt;
  logic [NUM_LOOPS-1:0][DEN24_W-1:0] den24_r, den24_nxt;
  logic [ZDA_OFS_W-1:0] zda_ofs_r;

  assign en_rise = synth_loop_enable & ~en_q_r;

  always_comb
  begin
    pdiv_nxt = pdiv_r;
    if (res_div_ok(pdiv_cfg.res))
      pdiv_nxt.res = pdiv_cfg.res;
    if (s2_div_ok(pdiv_cfg.s2))
      pdiv_nxt.s2 = pdiv_cfg.s2;
    if (s1_div_ok(pdiv_cfg.s1p))
      pdiv_nxt.s1p = pdiv_cfg.s1p;
    if (s1_div_ok(pdiv_cfg.s1s))
      pdiv_nxt.s1s = pdiv_cfg.s1s;
    fb_nxt = fb_r;
    fb_rej_nxt = 1'b1;
    if (fb_cfg.pre != '0 && fb_cfg.den != '0)
    begin
      fb_nxt = fb_cfg;
      fb_rej_nxt = 1'b0;
    end
    out_src_nxt = out_src_r;
    for (int i = 0; i < NUM_OUTS; i++)
    begin
      if (src_allowed(i, src_cfg[i >= 4 ? (i & ~1) : i]))
        out_src_nxt[i] = src_cfg[i >= 4 ? (i & ~1) : i];
    end
    ref_route_nxt = REF_ROUTE_NONE;
    if (ref_route_en && $onehot(ref_route_sel) && (ref_route_sel & ~REF_ROUTE_MASK) == '0)
      ref_route_nxt = ref_route_sel;
    den24_nxt = den24_r;
    for (int l = 0; l < NUM_LOOPS; l++)
    begin
      if (!dl_mode[l] && den24_cfg[l] != '0)
        den24_nxt[l] = den24_cfg[l];
    end
    den_fixed_nxt = dl_mode;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      en_q_r <= '0;
      pdiv_r <= PDIV_RST;
      fb_r <= FB_RST;
      fb_rej_r <= 1'b0;
      out_src_r <= '{default: SRC_RST};
      ref_route_r <= REF_ROUTE_NONE;
      den_fixed_r <= '0;
      den24_r <= {NUM_LOOPS{DEN24_RST}};
      zda_ofs_r <= '0;
    end
    else if (ce)
    begin
      en_q_r <= synth_loop_enable;
      pdiv_r <= pdiv_nxt;
      fb_r <= fb_nxt;
      fb_rej_r <= fb_rej_nxt;
      out_src_r <= out_src_nxt;
      ref_route_r <= ref_route_nxt;
      den_fixed_r <= den_fixed_nxt;
      den24_r <= den24_nxt;
      zda_ofs_r <= zda_offset_cfg;
    end
  end

  // ********************
  // Calibration and dividers
  // ********************
  logic [NUM_REFS-1:0] ref_pulse;
  logic fb_pulse, sel_ref_pulse;

  for (genvar l = 0; l < NUM_LOOPS; l++)
  begin : g_cal
    scos_cal_seq u_cal (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .ce(ce),
      .enable(synth_loop_enable[l]),
      .restart(en_rise[l] | soft_rst),
      .xo_ok(xo_ok),
      .locked(lock_s[l]),
      .cal_run(cal_run[l]),
      .ready(loop_ready[l])
    );
  end

  for (genvar r = 0; r < NUM_REFS; r++)
  begin : g_rdiv
    scos_pulse_div #(.W(REF_DIV_W)) u_rdiv (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .ce(ce),
      .tick(ref_edge[r]),
      .div(ref_div_cfg[r]),
      .pulse(ref_pulse[r])
    );
  end

  scos_pulse_div #(.W(PRE_W)) u_pre (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .ce(ce),
    .tick(fb_edge),
    .div(fb_r.pre),
    .pulse(fb_pulse)
  );

  assign sel_ref_pulse = ref_pulse[ref_sel];

  // ********************
  // Phase comparator and loop filter
  // ********************
  logic [PH_W-1:0] ph_cnt_r, ph_cnt_nxt, per_r, per_nxt;
  logic signed [PH_W:0] corr_r, corr_nxt;
  logic corr_v_r, corr_v_nxt;
  logic [FRAC_W-1:0] num_r, num_nxt;

  always_comb
  begin
    ph_cnt_nxt = (ph_cnt_r == '1) ? ph_cnt_r : ph_cnt_r + 1'b1;
    per_nxt = per_r;
    corr_nxt = corr_r;
    corr_v_nxt = 1'b0;
    if (sel_ref_pulse)
    begin
      per_nxt = ph_cnt_r;
      ph_cnt_nxt = '0;
    end
    if (fb_pulse)
    begin
      corr_v_nxt = 1'b1;
      if (ph_cnt_r > (per_r >> 1))
        corr_nxt = $signed({1'b0, ph_cnt_r}) - $signed({1'b0, per_r});
      else
        corr_nxt = $signed({1'b0, ph_cnt_r});
    end
    num_nxt = num_r;
    if (!dl_mode[DL_SYNTH])
      num_nxt = fb_r.num;
    else if (corr_v_r)
      num_nxt = num_r + (FRAC_W'(corr_r) << LF_SHIFT);
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ph_cnt_r <= '0;
      per_r <= '0;
      corr_r <= '0;
      corr_v_r <= 1'b0;
      num_r <= '0;
    end
    else if (ce)
    begin
      ph_cnt_r <= ph_cnt_nxt;
      per_r <= per_nxt;
      corr_r <= corr_nxt;
      corr_v_r <= corr_v_nxt;
      num_r <= num_nxt;
    end
  end

  // ********************
  // Output gating
  // ********************
  logic [NUM_OUTS-1:0] src_ready, live_r, mute_r, mute_nxt, sync_r, sync_nxt;
  logic [2:0] zda_r, zda_nxt;

  always_comb
  begin
    src_ready = '0;
    for (int i = 0; i < NUM_OUTS; i++)
    begin
      case (out_src_r[i])
        SRC_RES:
          src_ready[i] = loop_ready[LOOP_RES] &&
            (pdiv_r.res == RES_DIV_BYP || bank_of(i) != RES_EXCL_BANK);
        SRC_S2:
          src_ready[i] = loop_ready[LOOP_S2];
        SRC_S1P, SRC_S1S:
          src_ready[i] = loop_ready[LOOP_S1];
        SRC_XO:
          src_ready[i] = xo_ok;
        SRC_REF:
          src_ready[i] = ref_route_r != REF_ROUTE_NONE;
        default:
          src_ready[i] = 1'b0;
      endcase
    end
    mute_nxt = mute_sel & ~src_ready;
    sync_nxt = sync_req ? sync_en : '0;
    zda_nxt = zda_en & {src_ready[ZDA_OUT2], src_ready[ZDA_OUT1], src_ready[ZDA_OUT0]};
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      live_r <= '0;
      mute_r <= '1;
      sync_r <= '0;
      zda_r <= '0;
    end
    else if (ce)
    begin
      live_r <= src_ready;
      mute_r <= mute_nxt;
      sync_r <= sync_nxt;
      zda_r <= zda_nxt;
    end
  end

  assign pdiv = pdiv_r;
  assign fb = fb_r;
  assign fb_reject = fb_rej_r;
  assign den_fixed = den_fixed_r;
  assign den24 = den24_r;
  assign dl_num = num_r;
  assign corr_word = corr_r;
  assign corr_valid = corr_v_r;
  assign out_src = out_src_r;
  assign src_live = live_r;
  assign ref_route = ref_route_r;
  assign out_mute = mute_r;
  assign out_sync = sync_r;
  assign zda_active = zda_r;
  assign zda_offset = zda_ofs_r;

  // ********************
  // Assertions
  // ********************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  cal_start_a: assert property (ce && en_rise[1] ##1 ce && xo_ok && synth_loop_enable[1] && !soft_rst |=> cal_run[1])
    else $error("Loop calibration did not start after enable rose.");
  mute_hold_a: assert property (ce && mute_sel[0] && !src_ready[0] |=> out_mute[0])
    else $error("Output left unmuted before its source was ready.");
  res_div_a: assert property (res_div_ok(pdiv.res))
    else $error("Resonator post-divider holds an illegal value.");
  excl_bank_a: assert property (ce && out_src_r[12] == SRC_RES && pdiv_r.res != RES_DIV_BYP |=> !src_live[12])
    else $error("Divided resonator clock reached the excluded bank.");
  post_div_a: assert property (s2_div_ok(pdiv.s2) && s1_div_ok(pdiv.s1p) && s1_div_ok(pdiv.s1s))
    else $error("Synth post-divider holds an illegal value.");
  corr_out_a: assert property (ce && fb_pulse |=> corr_valid)
    else $error("No correction word after a feedback pulse.");
  num_track_a: assert property (ce && !dl_mode[DL_SYNTH] |=> dl_num == $past(fb_r.num))
    else $error("Numerator does not follow the programmed value.");
  fb_legal_a: assert property (fb.pre != '0 && fb.den != '0)
    else $error("Feedback prescaler or denominator is zero.");
  sync_pulse_a: assert property (ce && sync_req && sync_en[0] |=> out_sync[0] ##1
    (!out_sync[0] || $past(sync_req) || !$past(ce)))
    else $error("Sync pulse missing or too long.");
  pair_sel_a: assert property (out_src[6] == out_src[7] && out_src[5] inside {SRC_RES, SRC_S2})
    else $error("Output pair selections differ.");
  ref_route_a: assert property (ce && !ref_route_en |=> ref_route == REF_ROUTE_NONE)
    else $error("Reference routed while routing bit is clear.");
  den_fix_a: assert property (ce && dl_mode[1] |=> den_fixed[1] && $stable(den24[1]))
    else $error("Digital-loop synth not on fixed denominator.");

endmodule : scos_top

`default_nettype wire

// ==== pkg/scos_pkg.sv ====
package scos_pkg;

  // ********************
  // Sizes and timing
  // ********************
  localparam int NUM_LOOPS = 3;
  localparam int NUM_OUTS = 14;
  localparam int NUM_REFS = 4;
  localparam int REF_DIV_W = 16;
  localparam int PRE_W = 33;
  localparam int FB_INT_W = 33;
  localparam int FRAC_W = 40;
  localparam int DEN24_W = 24;
  localparam int ZDA_OFS_W = 16;
  localparam int PH_W = 17;
  localparam int SYNC_W = 9;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CAL_TIME_NS = 2000;
  localparam int CAL_CYC = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LF_SHIFT_DEF = 4;

  // ********************
  // Loops, banks and limits
  // ********************
  localparam int LOOP_S1 = 0;
  localparam int LOOP_S2 = 1;
  localparam int LOOP_RES = 2;
  localparam int RES_EXCL_BANK = 4;
  localparam int ZDA_OUT0 = 0;
  localparam int ZDA_OUT1 = 4;
  localparam int ZDA_OUT2 = 10;
  localparam logic [4:0] RES_DIV_BYP = 5'h01;
  localparam logic [4:0] RES_DIV_MAX8 = 5'h08;
  localparam logic [4:0] RES_DIV2_MIN = 5'h0a;
  localparam logic [4:0] RES_DIV2_MAX = 5'h10;
  localparam logic [3:0] S2_DIV_MIN = 4'h2;
  localparam logic [3:0] S2_DIV_MAX = 4'hd;
  localparam logic [2:0] S1_DIV_MIN = 3'h2;
  localparam logic [2:0] S1_DIV_MAX = 3'h7;
  localparam logic [4:0] REF_ROUTE_NONE = 5'h00;
  localparam logic [4:0] REF_ROUTE_MASK = 5'h0f;

  // ********************
  // Types
  // ********************
  typedef enum logic [2:0] {SRC_RES, SRC_S2, SRC_S1P, SRC_S1S, SRC_XO, SRC_REF} scos_src_t;
  typedef enum logic [2:0] {CAL_IDLE, CAL_WAIT_XO, CAL_RUN, CAL_LOCK, CAL_READY} scos_cal_st_t;

  typedef struct packed {
    logic [4:0] res;
    logic [3:0] s2;
    logic [2:0] s1p;
    logic [2:0] s1s;
  } scos_pdiv_t;

  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic [FB_INT_W-1:0] intg;
    logic [FRAC_W-1:0] num;
    logic [FRAC_W-1:0] den;
  } scos_fb_t;

  localparam scos_pdiv_t PDIV_RST = '{res: RES_DIV_BYP, s2: S2_DIV_MIN, s1p: S1_DIV_MIN, s1s: S1_DIV_MIN};
  localparam scos_fb_t FB_RST = '{pre: 33'h1, intg: 33'h1, num: 40'h0, den: 40'h1};
  localparam logic [DEN24_W-1:0] DEN24_RST = 24'h1;
  localparam scos_src_t SRC_RST = SRC_RES;

  // ********************
  // Checks
  // ********************
  function automatic logic res_div_ok(input logic [4:0] v);
    return (v >= RES_DIV_BYP && v <= RES_DIV_MAX8) || (v >= RES_DIV2_MIN && v <= RES_DIV2_MAX && !v[0]);
  endfunction : res_div_ok

  function automatic logic s2_div_ok(input logic [3:0] v);
    return v >= S2_DIV_MIN && v <= S2_DIV_MAX;
  endfunction : s2_div_ok

  function automatic logic s1_div_ok(input logic [2:0] v);
    return v >= S1_DIV_MIN && v <= S1_DIV_MAX;
  endfunction : s1_div_ok

  function automatic logic src_allowed(input int idx, input scos_src_t s);
    if (idx < 2)
      return s <= SRC_REF;
    else if (idx < 4)
      return s inside {SRC_RES, SRC_S2, SRC_S1P};
    else
      return s inside {SRC_RES, SRC_S2};
  endfunction : src_allowed

  function automatic int bank_of(input int idx);
    return idx < 2 ? 0 : idx < 4 ? 1 : idx < 8 ? 2 : idx < 12 ? 3 : 4;
  endfunction : bank_of

endpackage : scos_pkg

// ==== src/scos_pulse_div.sv ====
`timescale 1ns/1ps
`default_nettype none

module scos_pulse_div
#(
  parameter int W = 16
)
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic tick,
  input wire logic [W-1:0] div,
  output logic pulse
);

  // ********************
  // Tick divider
  // ********************
  if (W < 1 || W > 64)
  begin : g_bad_w
    $error("Divider width out of range.");
  end

  logic [W-1:0] cnt_r, cnt_nxt;
  logic pulse_r, pulse_nxt;

  always_comb
  begin
    cnt_nxt = cnt_r;
    pulse_nxt = 1'b0;
    if (tick)
    begin
      if (({1'b0, cnt_r} + 1'b1) >= {1'b0, div})
      begin
        cnt_nxt = '0;
        pulse_nxt = 1'b1;
      end
      else
        cnt_nxt = cnt_r + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_r <= '0;
      pulse_r <= 1'b0;
    end
    else if (ce)
    begin
      cnt_r <= cnt_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  assign pulse = pulse_r;

endmodule : scos_pulse_div

`default_nettype wire

// ==== src/scos_cal_seq.sv ====
`timescale 1ns/1ps
`default_nettype none

module scos_cal_seq
  import scos_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic enable,
  input wire logic restart,
  input wire logic xo_ok,
  input wire logic locked,
  output logic cal_run,
  output logic ready
);

  // ********************
  // Calibration sequence
  // ********************
  localparam int TW = $clog2(CAL_CYC + 1);

  scos_cal_st_t st_r, st_nxt;
  logic [TW-1:0] tmr_r, tmr_nxt;
  logic run_r, run_nxt, rdy_r, rdy_nxt;

  always_comb
  begin
    st_nxt = st_r;
    tmr_nxt = tmr_r;
    case (st_r)
      CAL_IDLE:
        if (enable)
          st_nxt = CAL_WAIT_XO;
      CAL_WAIT_XO:
        if (xo_ok)
        begin
          st_nxt = CAL_RUN;
          tmr_nxt = TW'(CAL_CYC - 1);
        end
      CAL_RUN:
        if (tmr_r == '0)
          st_nxt = CAL_LOCK;
        else
          tmr_nxt = tmr_r - 1'b1;
      CAL_LOCK:
        if (locked)
          st_nxt = CAL_READY;
      CAL_READY:
        if (!locked)
          st_nxt = CAL_LOCK;
      default:
        st_nxt = CAL_IDLE;
    endcase
    if (!enable)
      st_nxt = CAL_IDLE;
    else if (restart)
      st_nxt = CAL_WAIT_XO;
    run_nxt = st_nxt == CAL_RUN;
    rdy_nxt = st_nxt == CAL_READY;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r <= CAL_IDLE;
      tmr_r <= '0;
      run_r <= 1'b0;
      rdy_r <= 1'b0;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      run_r <= run_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  assign cal_run = run_r;
  assign ready = rdy_r;

endmodule : scos_cal_seq

`default_nettype wire

// ==== verification/scos_far_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ********************
// Crystal, loop lock and clock pins
// ********************
module scos_far_model
  import scos_pkg::*;
#(
  parameter int LOCK_DLY = 20
)
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic xo_on,
  input wire logic [NUM_LOOPS-1:0] cal_run,
  output logic xo_present,
  output logic [NUM_LOOPS-1:0] loop_lock,
  output logic [NUM_REFS-1:0] ref_in,
  output logic fb_in
);
  logic [NUM_LOOPS-1:0] cal_seen;
  logic [7:0] cnt [NUM_LOOPS];
  logic [7:0] tgl;
  // Lock comes a while after a finished calibration and drops while one runs.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      xo_present <= 1'b0;
      tgl <= 8'h00;
      cal_seen <= '0;
      loop_lock <= '0;
      for (int i = 0; i < NUM_LOOPS; i++)
        cnt[i] <= 8'h00;
    end
    else
    begin
      xo_present <= xo_on;
      tgl <= tgl + 8'h01;
      for (int i = 0; i < NUM_LOOPS; i++)
      begin
        if (cal_run[i])
        begin
          cal_seen[i] <= 1'b1;
          cnt[i] <= 8'h00;
          loop_lock[i] <= 1'b0;
        end
        else if (cal_seen[i] && cnt[i] < 8'(LOCK_DLY))
          cnt[i] <= cnt[i] + 8'h01;
        else
          loop_lock[i] <= cal_seen[i];
      end
    end
  end
  assign ref_in = tgl[4:1];
  assign fb_in = tgl[5];
endmodule : scos_far_model
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ********************
// Testbench
// ********************
module tb
  import scos_pkg::*;
;
  typedef struct {scos_pdiv_t cfg; scos_pdiv_t exp;} scos_row_t;
  scos_row_t rows [6] = '{
    '{'{5'h08, 4'hd, 3'h7, 3'h2}, '{5'h08, 4'hd, 3'h7, 3'h2}},
    '{'{5'h09, 4'he, 3'h1, 3'h7}, '{5'h08, 4'hd, 3'h7, 3'h7}},
    '{'{5'h10, 4'h2, 3'h0, 3'h3}, '{5'h10, 4'h2, 3'h7, 3'h3}},
    '{'{5'h0b, 4'h0, 3'h2, 3'h0}, '{5'h10, 4'h2, 3'h2, 3'h3}},
    '{'{5'h0a, 4'hc, 3'h6, 3'h0}, '{5'h0a, 4'hc, 3'h6, 3'h3}},
    '{'{5'h00, 4'h1, 3'h7, 3'h2}, '{5'h0a, 4'hc, 3'h7, 3'h2}}};
  logic [10:0] rt [8] = '{11'h421, 11'h442, 11'h484, 11'h508, 11'h460, 11'h100, 11'h400, 11'h600};
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic soft_rst = 1'b0;
  logic xo_on = 1'b0;
  logic xo_present, fb_in, fb_reject;
  logic [2:0] en = 3'h7;
  logic [2:0] loop_lock, cal_run, loop_ready;
  logic [3:0] ref_in;
  logic [1:0] ref_sel = 2'h0;
  scos_pdiv_t pdiv_cfg = PDIV_RST;
  scos_pdiv_t pdiv;
  scos_fb_t fb_cfg = FB_RST;
  scos_fb_t fb;
  scos_src_t [NUM_OUTS-1:0] src_cfg = '{default: SRC_RES};
  scos_src_t [NUM_OUTS-1:0] out_src;
  logic route_en = 1'b0;
  logic [4:0] route_sel = 5'h00;
  logic [4:0] ref_route;
  logic sync_req = 1'b0;
  logic [13:0] sync_en = 14'h0000;
  logic [13:0] out_mute, out_sync;
  logic [13:0] mute_sel = 14'h3fff;
  logic [13:0] src_live;
  logic [2:0] dl_mode = 3'h0;
  logic [2:0][23:0] den24_cfg = {3{24'h000005}};
  logic [2:0] den_fixed;
  logic [2:0][23:0] den24;
  logic [39:0] dl_num;
  logic [39:0] num0;
  logic signed [17:0] corr_word;
  logic signed [17:0] corr0;
  logic corr_valid;
  logic [2:0] zda_active;
  logic [15:0] zda_offset;
  int err_count = 0;
  int checks_done = 0;
  int n;

  always #5 ref_clk = ~ref_clk;

  scos_far_model far (.ref_clk(ref_clk), .arst_n(arst_n), .xo_on(xo_on), .cal_run(cal_run),
    .xo_present(xo_present), .loop_lock(loop_lock), .ref_in(ref_in), .fb_in(fb_in));

  scos_top dut (.ref_clk(ref_clk), .arst_n(arst_n), .ce(1'b1), .soft_rst(soft_rst),
    .xo_present(xo_present), .loop_lock(loop_lock), .ref_in(ref_in), .fb_in(fb_in),
    .synth_loop_enable(en), .dl_mode(dl_mode), .pdiv_cfg(pdiv_cfg), .fb_cfg(fb_cfg),
    .den24_cfg(den24_cfg), .ref_div_cfg({4{16'h0004}}), .ref_sel(ref_sel), .src_cfg(src_cfg),
    .ref_route_en(route_en), .ref_route_sel(route_sel), .mute_sel(mute_sel), .sync_req(sync_req),
    .sync_en(sync_en), .zda_en(3'h7), .zda_offset_cfg(16'h0010), .cal_run(cal_run),
    .loop_ready(loop_ready), .pdiv(pdiv), .fb(fb), .fb_reject(fb_reject), .den_fixed(den_fixed),
    .den24(den24), .dl_num(dl_num), .corr_word(corr_word), .corr_valid(corr_valid), .out_src(out_src),
    .src_live(src_live), .ref_route(ref_route), .out_mute(out_mute), .out_sync(out_sync),
    .zda_active(zda_active), .zda_offset(zda_offset));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic complete_run();
    $display("Counts: %0d checks, %0d errors", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run

  // Waits at falling edges for a calibration or ready bit, with a bound.
  task automatic wait_bit(input int lp, input bit rdy, input logic lvl);
    int k;
    k = 0;
    while (((rdy ? loop_ready[lp] : cal_run[lp]) !== lvl) && k < 1000)
    begin
      @(negedge ref_clk);
      k++;
    end
    if (k >= 1000)
    begin
      err_count++;
      complete_run();
    end
  endtask : wait_bit

  task automatic settle();
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : settle

  initial
  begin
    repeat (3) @(negedge ref_clk);
    chk(out_mute, 14'h3fff);
    chk(pdiv, PDIV_RST);
    @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (20) @(negedge ref_clk);
    chk(cal_run, 3'h0);
    xo_on <= 1'b1;
    wait_bit(0, 1'b0, 1'b1);
    chk(out_mute, 14'h3fff);
    n = 0;
    while (cal_run[0] === 1'b1 && n < 1000)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk(n, CAL_CYC);
    for (int i = 0; i < NUM_LOOPS; i++)
      wait_bit(i, 1'b1, 1'b1);
    settle();
    chk(out_mute, 14'h0000);
    chk({zda_active, zda_offset}, {3'h7, 16'h0010});
    $display("Test calibration done");
    @(posedge ref_clk);
    fb_cfg.intg <= 33'h5;
    en[1] <= 1'b0;
    @(posedge ref_clk);
    en[1] <= 1'b1;
    wait_bit(1, 1'b0, 1'b1);
    chk(cal_run, 3'h2);
    chk(loop_ready, 3'h5);
    wait_bit(1, 1'b1, 1'b1);
    chk(fb.intg, 33'h5);
    $display("Test recalibration done");
    foreach (rows[i])
    begin
      @(posedge ref_clk);
      pdiv_cfg <= rows[i].cfg;
      settle();
      chk(pdiv, rows[i].exp);
    end
    settle();
    chk(out_mute, 14'h3000);
    chk(src_live, 14'h0fff);
    @(posedge ref_clk);
    mute_sel <= 14'h1fff;
    settle();
    chk(out_mute, 14'h1000);
    $display("Test post dividers done");
    @(posedge ref_clk);
    src_cfg[0] <= SRC_REF;
    src_cfg[1] <= SRC_REF;
    src_cfg[2] <= SRC_S1P;
    src_cfg[3] <= SRC_S1P;
    src_cfg[4] <= SRC_S2;
    src_cfg[6] <= SRC_S2;
    settle();
    chk(out_src[1:0], {SRC_REF, SRC_REF});
    chk(out_src[7:2], {SRC_S2, SRC_S2, SRC_S2, SRC_S2, SRC_S1P, SRC_S1P});
    @(posedge ref_clk);
    src_cfg[2] <= SRC_S1S;
    src_cfg[3] <= SRC_S1S;
    src_cfg[4] <= SRC_XO;
    src_cfg[6] <= SRC_XO;
    settle();
    chk(out_src[7:2], {SRC_S2, SRC_S2, SRC_S2, SRC_S2, SRC_S1P, SRC_S1P});
    foreach (rt[i])
    begin
      @(posedge ref_clk);
      route_en <= rt[i][10];
      route_sel <= rt[i][9:5];
      settle();
      chk(ref_route, rt[i][4:0]);
      settle();
      chk(out_mute[0], rt[i][4:0] == 5'h00);
    end
    $display("Test sources done");
    @(posedge ref_clk);
    fb_cfg.pre <= 33'h0;
    settle();
    chk({fb.intg, fb_reject}, {33'h5, 1'b1});
    @(posedge ref_clk);
    fb_cfg <= '{pre: 33'h1ffffffff, intg: 33'h1ffffffff, num: 40'hffffffffff, den: 40'h0000000003};
    settle();
    chk({fb.pre, fb.num[3:0], fb.den[3:0], fb_reject}, {33'h1ffffffff, 8'hf3, 1'b0});
    @(posedge ref_clk);
    sync_en <= 14'h0411;
    sync_req <= 1'b1;
    @(posedge ref_clk);
    sync_req <= 1'b0;
    @(negedge ref_clk);
    chk(out_sync, 14'h0411);
    settle();
    chk(out_sync, 14'h0000);
    @(posedge ref_clk);
    fb_cfg <= '{pre: 33'h1, intg: 33'h5, num: 40'h0000000100, den: 40'h0000000001};
    dl_mode <= 3'h2;
    den24_cfg <= {3{24'h000009}};
    settle();
    settle();
    chk(den_fixed, 3'h2);
    chk(den24[1], 24'h000005);
    chk({den24[2], den24[0]}, {24'h000009, 24'h000009});
    chk(dl_num, 40'h0000000100);
    @(posedge ref_clk);
    dl_mode <= 3'h6;
    @(negedge ref_clk);
    n = 0;
    while (corr_valid !== 1'b1 && n < 200)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk(corr_valid, 1'b1);
    num0 = dl_num;
    corr0 = corr_word;
    settle();
    chk(dl_num, num0 + (40'(corr0) << LF_SHIFT_DEF));
    $display("Test digital loop done");
    @(posedge ref_clk);
    soft_rst <= 1'b1;
    @(posedge ref_clk);
    soft_rst <= 1'b0;
    wait_bit(2, 1'b0, 1'b1);
    chk(cal_run, 3'h7);
    $display("Test soft reset done");
    complete_run();
  end
endmodule : tb
`default_nettype wire
